// ---- bridge_cmd_cfg.svh ----
`ifndef BRIDGE_CMD_CFG_SVH
`define BRIDGE_CMD_CFG_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define ID_REG_OFF        12'h000
`define DEVICE_CODE_OFF   12'h002
`define CMD_REG_OFF       12'h004
`define STATUS_REG_OFF    12'h006

// ----------------------------------------
// Command field positions
// ----------------------------------------
`define IO_EN_BIT         0
`define MEM_EN_BIT        1
`define BM_EN_BIT         2
`define PERR_EN_BIT       6
`define SERR_EN_BIT       8
`define INT_DIS_BIT       10

// Writable bits 0,1,2,6,8,10; all others read zero
`define CMD_WRITE_MASK    16'h0547
`define CMD_RESET         16'h0000

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define MDPE_BIT          8
`define STATUS_RESET      16'h0000

`endif

// ---- bridge_cmd_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface bridge_cmd_if;
	logic                         bm_en;
	logic                         serr_en;
	bridge_cmd_pkg::sec_decision_t decision;

	modport reg_side (
		output bm_en,
		output serr_en,
		input  decision
	);
	modport gate_side (
		input  bm_en,
		input  serr_en,
		output decision
	);
endinterface

`default_nettype wire

// ---- bridge_cmd_pkg.sv ----
package bridge_cmd_pkg;

	// Kind of request arriving on the secondary side
	typedef enum logic [3:0] {
		SEC_MEM_RD     = 4'h0,
		SEC_MEM_WR     = 4'h1,
		SEC_IO_RD      = 4'h2,
		SEC_IO_WR      = 4'h3,
		SEC_MSI_WR     = 4'h4,
		SEC_CPL        = 4'h5,
		SEC_MSG_OTHER  = 4'h6,
		SEC_ERR_COR    = 4'h7,
		SEC_ERR_NONFAT = 4'h8,
		SEC_ERR_FATAL  = 4'h9,
		SEC_INTX       = 4'ha,
		SEC_CFG_OTHER  = 4'hb
	} sec_kind_t;

	// Outcome of a secondary request
	typedef enum logic [1:0] {
		DEC_NONE    = 2'h0,
		DEC_FORWARD = 2'h1,
		DEC_UR      = 2'h2,
		DEC_DROP    = 2'h3
	} sec_decision_t;

endpackage

// ---- bridge_command_header_regs.sv ----
// How it works
// RL1: I/O enable gates claiming I/O window accesses
// RL2: Memory enable gates claiming memory window accesses
// RL3: No upstream memory/IO/MSI requests without master enable
// RL4: Non-posted requests get UR when master disabled
// RL5: Completions and other requests ignore master enable
// RL6: Parity enable gates poisoned-data status bit setting
// RL7: Own errors reported if system or devctl enabled
// RL8: Forward nonfatal/fatal messages when system error enabled
// RL9: Correctable error messages always forwarded
// RL10: Interrupt disable gates own INTx messages
// RL11: Forwarded legacy interrupts unaffected by disable
// RL12: Unused command bits read zero, read-only
// RL13: Read-only vendor code in low half
// RL14: Read-only device code in high half
// RL15: All command enables reset to zero
// RL16: Parity status bit cleared by writing one
// RL17: Byte enables limit writes to addressed bytes
`timescale 1ns/1ps
`default_nettype none
`include "bridge_cmd_cfg.svh"

module bridge_command_header_regs #(
	// Arbitrary identification values, replace per product
	parameter logic [15:0] VENDOR_CODE = 16'h5a5a,
	parameter logic [15:0] DEVICE_CODE = 16'h0c0d
) (
	// Clock and reset
	input  wire logic                      CLK,
	input  wire logic                      NRST,
	// Configuration requests
	input  wire logic                      CFG_REQ,
	input  wire logic                      CFG_WR,
	input  wire logic [11:0]               CFG_ADDR,
	input  wire logic [3:0]                CFG_BE,
	input  wire logic [31:0]               CFG_WDATA,
	output logic                           CFG_ACK,
	output logic [31:0]                    CFG_RDATA,
	// Primary-side accesses
	input  wire logic                      PRI_VALID,
	input  wire logic                      PRI_IS_IO,
	input  wire logic                      PRI_IN_IO_WIN,
	input  wire logic                      PRI_IN_MEM_WIN,
	input  wire logic                      PRI_IN_PREF_WIN,
	output logic                           PRI_CLAIM,
	output logic                           PRI_IGNORE,
	// Secondary-side requests
	input  wire logic                      SEC_VALID,
	input  wire bridge_cmd_pkg::sec_kind_t SEC_KIND,
	input  wire logic                      SEC_NONPOSTED,
	output logic                           SEC_FORWARD,
	output logic                           SEC_UR,
	output logic                           SEC_DROP,
	// Error events and reporting
	input  wire logic                      OWN_NONFATAL,
	input  wire logic                      OWN_FATAL,
	input  wire logic                      DEVCTL_NONFATAL_EN,
	input  wire logic                      DEVCTL_FATAL_EN,
	input  wire logic                      POISON_CPL_RX,
	input  wire logic                      POISON_WR_TX,
	output logic                           ERR_NONFATAL_MSG,
	output logic                           ERR_FATAL_MSG,
	// Own legacy interrupt
	input  wire logic                      OWN_INT_PENDING,
	output logic                           INTX_ASSERT_MSG,
	output logic                           INTX_DEASSERT_MSG
);

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [15:0] command_q;
	logic [15:0] command_d;
	logic        mdpe_q;
	logic        mdpe_d;
	logic        intx_sent_q;
	logic        intx_want;

	bridge_cmd_if cmd_bus ();

	// ----------------------------------------
	// Access decode
	// ----------------------------------------
	logic        cmd_hit;
	logic        id_hit;
	logic        cmd_wr;
	logic [31:0] rd_word;

	assign id_hit  = CFG_ADDR[11:2] == 10'(`ID_REG_OFF >> 2);
	assign cmd_hit = CFG_ADDR[11:2] == 10'(`CMD_REG_OFF >> 2);
	assign cmd_wr  = CFG_REQ && CFG_WR && cmd_hit;

	// ----------------------------------------
	// Command register
	// ----------------------------------------
	always_comb begin
		command_d = command_q;
		if (cmd_wr) begin
			if (CFG_BE[0]) // RL17
				command_d[7:0] = CFG_WDATA[7:0] & 8'(`CMD_WRITE_MASK); // RL12
			if (CFG_BE[1]) // RL17
				command_d[15:8] = CFG_WDATA[15:8] & 8'(`CMD_WRITE_MASK >> 8); // RL12
		end
	end

	always_ff @(posedge CLK) begin
		if (!NRST)
			command_q <= `CMD_RESET; // RL15
		else
			command_q <= command_d & `CMD_WRITE_MASK; // RL12
	end

	assign cmd_bus.bm_en   = command_q[`BM_EN_BIT];
	assign cmd_bus.serr_en = command_q[`SERR_EN_BIT];

	// ----------------------------------------
	// Master data parity error status
	// ----------------------------------------
	// A poison event in the clearing cycle still sets the bit
	always_comb begin
		mdpe_d = mdpe_q;
		if (cmd_wr && CFG_BE[3] && CFG_WDATA[16 + `MDPE_BIT])
			mdpe_d = 1'b0; // RL16
		if (command_q[`PERR_EN_BIT] && (POISON_CPL_RX || POISON_WR_TX))
			mdpe_d = 1'b1; // RL6
	end

	always_ff @(posedge CLK) begin
		if (!NRST)
			mdpe_q <= 1'(`STATUS_RESET >> `MDPE_BIT);
		else
			mdpe_q <= mdpe_d;
	end

	// ----------------------------------------
	// Read data and answer
	// ----------------------------------------
	always_comb begin
		rd_word = 32'h0000_0000;
		if (id_hit)
			rd_word = {DEVICE_CODE, VENDOR_CODE}; // RL13 RL14
		else if (cmd_hit)
			rd_word = {7'h00, mdpe_q, `MDPE_BIT'(0), command_q}; // RL12
	end

	// One-cycle answer; writes answer with zero data
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			CFG_ACK   <= 1'b0;
			CFG_RDATA <= 32'h0000_0000;
		end else begin
			CFG_ACK   <= CFG_REQ;
			CFG_RDATA <= (CFG_REQ && !CFG_WR) ? rd_word : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Primary-side claiming
	// ----------------------------------------
	logic pri_in_win;
	logic pri_enabled;

	assign pri_in_win  = PRI_IS_IO ? PRI_IN_IO_WIN : (PRI_IN_MEM_WIN || PRI_IN_PREF_WIN);
	assign pri_enabled = PRI_IS_IO ? command_q[`IO_EN_BIT] // RL1
	                               : command_q[`MEM_EN_BIT]; // RL2

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			PRI_CLAIM  <= 1'b0;
			PRI_IGNORE <= 1'b0;
		end else begin
			PRI_CLAIM  <= PRI_VALID && pri_in_win && pri_enabled; // RL1 RL2
			PRI_IGNORE <= PRI_VALID && pri_in_win && !pri_enabled; // RL1 RL2
		end
	end

	// ----------------------------------------
	// Secondary-side forwarding
	// ----------------------------------------
	upstream_request_gate gate (
		.cmd       (cmd_bus),
		.valid     (SEC_VALID),
		.kind      (SEC_KIND),
		.nonposted (SEC_NONPOSTED)
	);

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			SEC_FORWARD <= 1'b0;
			SEC_UR      <= 1'b0;
			SEC_DROP    <= 1'b0;
		end else begin
			SEC_FORWARD <= cmd_bus.decision == bridge_cmd_pkg::DEC_FORWARD; // RL5
			SEC_UR      <= cmd_bus.decision == bridge_cmd_pkg::DEC_UR; // RL4
			SEC_DROP    <= cmd_bus.decision == bridge_cmd_pkg::DEC_DROP; // RL3
		end
	end

	// ----------------------------------------
	// Own error reporting
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			ERR_NONFATAL_MSG <= 1'b0;
			ERR_FATAL_MSG    <= 1'b0;
		end else begin
			ERR_NONFATAL_MSG <= OWN_NONFATAL && (command_q[`SERR_EN_BIT] || DEVCTL_NONFATAL_EN); // RL7
			ERR_FATAL_MSG    <= OWN_FATAL && (command_q[`SERR_EN_BIT] || DEVCTL_FATAL_EN); // RL7
		end
	end

	// ----------------------------------------
	// Own legacy interrupt
	// ----------------------------------------
	// Setting the disable bit while asserted sends a deassert,
	// so the upstream resolved state never sticks high
	assign intx_want = OWN_INT_PENDING && !command_q[`INT_DIS_BIT]; // RL10

	always_ff @(posedge CLK) begin
		if (!NRST) begin
			intx_sent_q       <= 1'b0;
			INTX_ASSERT_MSG   <= 1'b0;
			INTX_DEASSERT_MSG <= 1'b0;
		end else begin
			intx_sent_q       <= intx_want;
			INTX_ASSERT_MSG   <= intx_want && !intx_sent_q; // RL10
			INTX_DEASSERT_MSG <= !intx_want && intx_sent_q; // RL10
		end
	end

endmodule

`default_nettype wire

// ---- bridge_command_header_regs_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module bchr_monitor (
	// Clock and reset
	input wire logic                      CLK,
	input wire logic                      NRST,
	// Watched ports
	input wire logic                      CFG_REQ,
	input wire logic                      CFG_ACK,
	input wire logic                      PRI_VALID,
	input wire logic                      PRI_IN_IO_WIN,
	input wire logic                      PRI_IN_MEM_WIN,
	input wire logic                      PRI_IN_PREF_WIN,
	input wire logic                      PRI_CLAIM,
	input wire logic                      PRI_IGNORE,
	input wire logic                      SEC_VALID,
	input wire bridge_cmd_pkg::sec_kind_t SEC_KIND,
	input wire logic                      SEC_NONPOSTED,
	input wire logic                      SEC_FORWARD,
	input wire logic                      SEC_UR,
	input wire logic                      SEC_DROP,
	input wire logic                      OWN_FATAL,
	input wire logic                      DEVCTL_FATAL_EN,
	input wire logic                      ERR_FATAL_MSG
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);
	a_cfg_answer: assert property (CFG_REQ |=> CFG_ACK) else $error("config ack missing");
	a_claim_excl: assert property (!(PRI_CLAIM && PRI_IGNORE)) else $error("claim and ignore together");
	a_out_window: assert property (PRI_VALID && !PRI_IN_IO_WIN && !PRI_IN_MEM_WIN && !PRI_IN_PREF_WIN
		|=> !PRI_CLAIM && !PRI_IGNORE) else $error("answer outside windows");
	a_one_decision: assert property (SEC_VALID |=> $onehot({SEC_FORWARD, SEC_UR, SEC_DROP}))
		else $error("decision not one-hot");
	a_idle_quiet: assert property (!SEC_VALID |=> !(SEC_FORWARD || SEC_UR || SEC_DROP)) else $error("stray decision");
	a_cpl_pass: assert property (SEC_VALID && SEC_KIND inside {bridge_cmd_pkg::SEC_CPL,
		bridge_cmd_pkg::SEC_MSG_OTHER, bridge_cmd_pkg::SEC_CFG_OTHER} |=> SEC_FORWARD) else $error("blocked pass");
	a_cor_pass: assert property (SEC_VALID && SEC_KIND == bridge_cmd_pkg::SEC_ERR_COR |=> SEC_FORWARD)
		else $error("correctable blocked");
	a_intx_pass: assert property (SEC_VALID && SEC_KIND == bridge_cmd_pkg::SEC_INTX |=> SEC_FORWARD)
		else $error("interrupt blocked");
	a_posted_no_ur: assert property (SEC_VALID && !SEC_NONPOSTED |=> !SEC_UR) else $error("posted got UR");
	a_fatal_report: assert property (OWN_FATAL && DEVCTL_FATAL_EN |=> ERR_FATAL_MSG) else $error("fatal lost");
	a_fatal_cause: assert property (!OWN_FATAL |=> !ERR_FATAL_MSG) else $error("fatal without cause");
	cover property (SEC_VALID ##1 SEC_UR);
	cover property (PRI_CLAIM);
	cover property (ERR_FATAL_MSG);
endmodule
bind bridge_command_header_regs bchr_monitor mon (.*);
`default_nettype wire

// ---- bridge_command_header_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module bridge_command_header_regs_tb;
	// Arbitrary identification values
	localparam logic [15:0] VC = 16'h1357;
	localparam logic [15:0] DC = 16'h2468;
	logic CLK, NRST, CFG_REQ, CFG_WR, CFG_ACK, PRI_VALID, PRI_IS_IO, PRI_IN_IO_WIN, PRI_IN_MEM_WIN;
	logic PRI_IN_PREF_WIN, PRI_CLAIM, PRI_IGNORE, SEC_VALID, SEC_NONPOSTED, SEC_FORWARD, SEC_UR, SEC_DROP;
	logic OWN_NONFATAL, OWN_FATAL, DEVCTL_NONFATAL_EN, DEVCTL_FATAL_EN, POISON_CPL_RX, POISON_WR_TX;
	logic ERR_NONFATAL_MSG, ERR_FATAL_MSG, OWN_INT_PENDING, INTX_ASSERT_MSG, INTX_DEASSERT_MSG;
	logic [11:0] CFG_ADDR;
	logic [3:0]  CFG_BE;
	logic [31:0] CFG_WDATA, CFG_RDATA, d;
	bridge_cmd_pkg::sec_kind_t SEC_KIND;
	int num_errors = 0, checked = 0, na = 0, nd = 0;
	bridge_command_header_regs #(.VENDOR_CODE(VC), .DEVICE_CODE(DC)) dut (.*);
	cfg_root_model rc (.*);
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		na += INTX_ASSERT_MSG;
		nd += INTX_DEASSERT_MSG;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic step;
		@(posedge CLK);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		rc.xfer(1'b0, a, 4'hf, 32'h0, d);
		chk(d, e);
	endtask
	task automatic wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] v);
		rc.xfer(1'b1, a, b, v, d);
	endtask
	task automatic pri(input logic io, input logic [2:0] win, input logic [1:0] e);
		{PRI_VALID, PRI_IS_IO, PRI_IN_IO_WIN, PRI_IN_MEM_WIN, PRI_IN_PREF_WIN} = {1'b1, io, win};
		step;
		PRI_VALID = 1'b0;
		chk(32'({PRI_CLAIM, PRI_IGNORE}), 32'(e));
		// Idle edge so the next call never re-raises valid in this time step
		step;
	endtask
	task automatic sec(input logic [3:0] k, input logic np, input logic [2:0] e);
		SEC_VALID     = 1'b1;
		SEC_KIND      = bridge_cmd_pkg::sec_kind_t'(k);
		SEC_NONPOSTED = np;
		step;
		SEC_VALID = 1'b0;
		chk(32'({SEC_FORWARD, SEC_UR, SEC_DROP}), 32'(e));
		step;
	endtask
	// Decision from kind, nonposted, master enable, system error enable
	function automatic logic [2:0] dec(input int k, input logic np, input logic bm, input logic se);
		if (k <= 4)
			return bm ? 3'b100 : (np ? 3'b010 : 3'b001);
		if (k == 8 || k == 9)
			return se ? 3'b100 : 3'b001;
		return 3'b100;
	endfunction
	task automatic wrap_up;
		$display("checks=%0d errors=%0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#400000;
		num_errors++;
		wrap_up;
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{NRST, PRI_VALID, PRI_IS_IO, PRI_IN_IO_WIN, PRI_IN_MEM_WIN, PRI_IN_PREF_WIN, SEC_VALID} = '0;
		SEC_KIND = bridge_cmd_pkg::SEC_MEM_RD;
		{SEC_NONPOSTED, OWN_NONFATAL, OWN_FATAL, DEVCTL_NONFATAL_EN, DEVCTL_FATAL_EN} = '0;
		{POISON_CPL_RX, POISON_WR_TX, OWN_INT_PENDING} = '0;
		repeat (20) step;
		NRST = 1'b1;
		rd(12'h004, 32'h0);
		wr(12'h000, 4'hf, 32'h0);
		rd(12'h000, {DC, VC});
		wr(12'h004, 4'h3, 32'hffff_ffff);
		rd(12'h004, 32'h0000_0547);
		wr(12'h004, 4'h1, 32'h0);
		rd(12'h004, 32'h0000_0500);
		$display("test registers done");
		pri(1'b1, 3'b100, 2'b01);
		pri(1'b0, 3'b010, 2'b01);
		wr(12'h004, 4'h3, 32'h0000_0003);
		pri(1'b1, 3'b100, 2'b10);
		pri(1'b0, 3'b001, 2'b10);
		pri(1'b0, 3'b000, 2'b00);
		$display("test primary done");
		for (int c = 0; c < 4; c++) begin
			wr(12'h004, 4'h3, {23'h0, c[1], 5'h0, c[0], 2'h0});
			DEVCTL_FATAL_EN    = c[0];
			DEVCTL_NONFATAL_EN = c[0] ^ c[1];
			for (int k = 0; k < 12; k++)
				for (int n = 0; n < 2; n++)
					sec(k[3:0], n[0], dec(k, n[0], c[0], c[1]));
			{OWN_NONFATAL, OWN_FATAL} = 2'b11;
			step;
			{OWN_NONFATAL, OWN_FATAL} = 2'b00;
			chk(32'({ERR_NONFATAL_MSG, ERR_FATAL_MSG}), 32'({c[1] | c[0], c[1] | c[0]}));
		end
		// Undefined request kind is dropped
		sec(4'hc, 1'b1, 3'b001);
		$display("test secondary done");
		wr(12'h004, 4'h3, 32'h0);
		POISON_CPL_RX = 1'b1;
		step;
		POISON_CPL_RX = 1'b0;
		rd(12'h004, 32'h0);
		wr(12'h004, 4'h3, 32'h0000_0040);
		POISON_WR_TX = 1'b1;
		step;
		POISON_WR_TX = 1'b0;
		rd(12'h004, 32'h0100_0040);
		wr(12'h004, 4'h8, 32'h0);
		rd(12'h004, 32'h0100_0040);
		wr(12'h004, 4'h8, 32'h0100_0000);
		rd(12'h004, 32'h0000_0040);
		$display("test parity done");
		OWN_INT_PENDING = 1'b1;
		repeat (4) step;
		chk(32'(na), 32'h1);
		wr(12'h004, 4'h3, 32'h0000_0400);
		repeat (4) step;
		chk(32'({na[3:0], nd[3:0]}), 32'h11);
		sec(4'ha, 1'b0, 3'b100);
		$display("test interrupt done");
		wrap_up;
	end
endmodule
`default_nettype wire

// ---- cfg_root_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cfg_root_model (
	// Clock
	input  wire logic        CLK,
	// Request
	output logic             CFG_REQ,
	output logic             CFG_WR,
	output logic [11:0]      CFG_ADDR,
	output logic [3:0]       CFG_BE,
	output logic [31:0]      CFG_WDATA,
	// Answer
	input  wire logic        CFG_ACK,
	input  wire logic [31:0] CFG_RDATA
);
	initial begin
		CFG_REQ = 1'b0;
		{CFG_WR, CFG_ADDR, CFG_BE, CFG_WDATA} = '0;
	end
	// Strobe for one edge, answer one edge later; no ack gives x
	task automatic xfer(input logic w, input logic [11:0] a, input logic [3:0] b, input logic [31:0] d,
		output logic [31:0] r);
		{CFG_REQ, CFG_WR, CFG_ADDR, CFG_BE, CFG_WDATA} = {1'b1, w, a, b, d};
		@(posedge CLK);
		#1;
		// Answer stands only in the cycle after the taking edge
		r = CFG_ACK ? CFG_RDATA : 32'hxxxxxxxx;
		CFG_REQ = 1'b0;
		// Released lines must not keep the old value
		{CFG_ADDR, CFG_BE, CFG_WDATA} = ~{a, b, d};
		@(posedge CLK);
		#1;
	endtask
endmodule
`default_nettype wire

// ---- upstream_request_gate.sv ----
`timescale 1ns/1ps
`default_nettype none

module upstream_request_gate (
	// Command bits in, decision out
	bridge_cmd_if.gate_side        cmd,
	// Secondary request
	input  wire logic                      valid,
	input  wire bridge_cmd_pkg::sec_kind_t kind,
	input  wire logic                      nonposted
);

	always_comb begin
		cmd.decision = bridge_cmd_pkg::DEC_NONE;
		if (valid) begin
			unique case (kind)
				bridge_cmd_pkg::SEC_MEM_RD,
				bridge_cmd_pkg::SEC_MEM_WR,
				bridge_cmd_pkg::SEC_IO_RD,
				bridge_cmd_pkg::SEC_IO_WR,
				bridge_cmd_pkg::SEC_MSI_WR: begin
					if (cmd.bm_en)
						cmd.decision = bridge_cmd_pkg::DEC_FORWARD;
					else if (nonposted)
						cmd.decision = bridge_cmd_pkg::DEC_UR; // RL4
					else
						cmd.decision = bridge_cmd_pkg::DEC_DROP; // RL3
				end
				// Completions and other traffic ignore bus master enable
				bridge_cmd_pkg::SEC_CPL,
				bridge_cmd_pkg::SEC_MSG_OTHER,
				bridge_cmd_pkg::SEC_CFG_OTHER: cmd.decision = bridge_cmd_pkg::DEC_FORWARD; // RL5
				bridge_cmd_pkg::SEC_ERR_COR:   cmd.decision = bridge_cmd_pkg::DEC_FORWARD; // RL9
				bridge_cmd_pkg::SEC_ERR_NONFAT,
				bridge_cmd_pkg::SEC_ERR_FATAL: begin
					cmd.decision = cmd.serr_en ? bridge_cmd_pkg::DEC_FORWARD
					                           : bridge_cmd_pkg::DEC_DROP; // RL8
				end
				bridge_cmd_pkg::SEC_INTX:      cmd.decision = bridge_cmd_pkg::DEC_FORWARD; // RL11
				default:                       cmd.decision = bridge_cmd_pkg::DEC_DROP;
			endcase
		end
	end

endmodule

`default_nettype wire
